// ---- rtl/fspc_pkg.sv ----
// Shared constants and types for the flash self-programming controller and its core end.
package fspc_pkg;
    // Pointer and array geometry.
    localparam int PTR_W       = 22;
    localparam int PTR_STEP_W  = 21;  // Only the low bits take part in auto-increment.
    localparam int ROW_LSB     = 10;  // Erase row field starts here.
    localparam int BLK_LSB     = 6;   // Program block field starts here.
    localparam int ROW_WORD_W  = 9;   // 512 words in one erase row.
    localparam int BLK_WORD_W  = 5;   // 32 words in one program block.
    localparam int HOLD_CNT    = 64;
    localparam int HOLD_AW     = 6;
    localparam int BYTE_W      = 8;
    localparam int WORD_W      = 16;
    localparam int DEF_ROW_BITS = 1;  // Default array size: two rows.

    // Control byte field positions.
    localparam int CTRL_FREE   = 4;
    localparam int CTRL_ABORT  = 3;
    localparam int CTRL_WRITE_ENABLE_BIT   = 2;
    localparam int CTRL_WR     = 1;

    // Unlock keys.
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // Long-operation time and its length in cycles of mclk.
    localparam int CLK_PERIOD_NS = 4;
    localparam int PROG_TIME_NS  = 1000000;
    localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Operations on the link.
    typedef enum logic [2:0] {
        OP_PTR_WR  = 3'h0,
        OP_TBL_RD  = 3'h1,
        OP_HOLD_LD = 3'h2,
        OP_CTRL_WR = 3'h3,
        OP_KEY_WR  = 3'h4,
        OP_CTRL_RD = 3'h5,
        OP_LAT_RD  = 3'h6,
        OP_KEY_RD  = 3'h7
    } fspc_op_type;

    // Unlock progress.
    typedef enum logic [1:0] {
        KEY_NONE  = 2'b00,
        KEY_HALF  = 2'b01,
        KEY_ARMED = 2'b11
    } fspc_key_type;

    // Device sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_RDWAIT = 2'b01,
        ST_ERASE  = 2'b11,
        ST_PROG   = 2'b10
    } fspc_state_type;

    // Core-end register map.
    localparam logic [3:0] REG_DATA = 4'h0;
    localparam logic [3:0] REG_CMD  = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam logic [3:0] REG_RSP  = 4'hc;
    localparam int CMD_INC   = 3;
    localparam int STAT_BUSY = 0;
    localparam int STAT_NEW  = 1;
endpackage

// ---- rtl/fspc_link_if.sv ----
// Link between the processor core end and the flash self-programming controller.
`timescale 1ns/1ns
interface fspc_link_if;
    import fspc_pkg::*;
    logic                 op_valid;
    fspc_op_type          op_code;
    logic                 op_inc;
    logic [PTR_W-1:0]     op_data;
    logic                 stall;
    logic                 rsp_valid;
    logic [BYTE_W-1:0]    rsp_data;

    // Device end of the link.
    modport dev  (input op_valid, op_code, op_inc, op_data, output stall, rsp_valid, rsp_data);
    // Processor core end of the link.
    modport core (output op_valid, op_code, op_inc, op_data, input stall, rsp_valid, rsp_data);
endinterface

// ---- rtl/fspc_device.sv ----
// Flash self-programming controller: byte reads, holding load, keyed row erase and program.
`timescale 1ns/1ns
module fspc_device
    import fspc_pkg::*;
#(
    parameter int ROW_BITS  = DEF_ROW_BITS,
    parameter int LONG_CYC  = PROG_CYCLES
)(
    // Clock, resets and clock enable.
    input  wire logic  mclk,
    input  wire logic  rst_b,
    input  wire logic  por_b,
    input  wire logic  ce,
    // Link to the processor core.
    fspc_link_if.dev   lk
);
    import fspc_pkg::*;

    localparam int WAW = ROW_BITS + ROW_WORD_W;
    localparam int CW  = $clog2(LONG_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(LONG_CYC - 1);
    localparam logic [ROW_WORD_W-1:0] ERASE_LAST = '1;
    localparam logic [ROW_WORD_W-1:0] PROG_LAST  = ROW_WORD_W'((1 << BLK_WORD_W) - 1);

    typedef struct packed {
        fspc_state_type                   st;
        logic [PTR_W-1:0]                 ptr;
        logic [BYTE_W-1:0]                latch;
        logic [HOLD_CNT-1:0][BYTE_W-1:0]  hold;
        logic                             free;
        logic                             write_enable_bit;
        logic                             wr;
        fspc_key_type                     key;
        logic                             rd_hi;
        logic [CW-1:0]                    cnt;
        logic [ROW_WORD_W-1:0]            idx;
        logic                             idx_done;
        logic [WAW-1:0]                   base;
        logic                             rsp_valid;
        logic [BYTE_W-1:0]                rsp_data;
    } fspc_dev_type;

    fspc_dev_type        r_reg;
    fspc_dev_type        r_next;
    logic [WORD_W-1:0]   mem [0:(1<<WAW)-1];
    logic [WORD_W-1:0]   mem_q;
    logic                mem_we;
    logic [WAW-1:0]      mem_wa;
    logic [WORD_W-1:0]   mem_wd;
    logic                abort_reg;
    logic                launch;
    logic                done;
    logic                ctrl_wr_acc;

    // Advances the pointer, keeping the top bit.
    function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p);
        ptr_step = {p[PTR_W-1], PTR_STEP_W'(p[PTR_STEP_W-1:0] + 1'b1)};
    endfunction

    // Picks one byte of a word by the low pointer bit.
    function automatic logic [BYTE_W-1:0] byte_of(input logic [WORD_W-1:0] w, input logic hi);
        byte_of = hi ? w[WORD_W-1:BYTE_W] : w[BYTE_W-1:0];
    endfunction

    // Assembles the control byte; unused bits read as zero.
    function automatic logic [BYTE_W-1:0] ctrl_byte(input fspc_dev_type s, input logic ab);
        ctrl_byte = '0;
        ctrl_byte[CTRL_FREE]  = s.free;
        ctrl_byte[CTRL_ABORT] = ab;
        ctrl_byte[CTRL_WRITE_ENABLE_BIT]  = s.write_enable_bit;
        ctrl_byte[CTRL_WR]    = s.wr;
    endfunction

    // Link handshake: nothing is taken while a read or long cycle is in progress.
    assign lk.stall     = (r_reg.st != ST_IDLE);
    assign lk.rsp_valid = r_reg.rsp_valid;
    assign lk.rsp_data  = r_reg.rsp_data;

    // Next-state logic for the whole controller.
    always_comb
    begin
        r_next      = r_reg;
        r_next.rsp_valid = 1'b0;
        mem_we      = 1'b0;
        mem_wa      = r_reg.base + WAW'(r_reg.idx);
        mem_wd      = {r_reg.hold[{r_reg.idx[BLK_WORD_W-1:0], 1'b1}],
                       r_reg.hold[{r_reg.idx[BLK_WORD_W-1:0], 1'b0}]};
        launch      = 1'b0;
        done        = 1'b0;
        ctrl_wr_acc = 1'b0;
        unique case (r_reg.st)
            ST_IDLE:
            begin
                if (lk.op_valid)
                begin
                    // Any other operation between the keys and the launch disarms.
                    if (lk.op_code != OP_KEY_WR)
                        r_next.key = KEY_NONE;
                    unique case (lk.op_code)
                        OP_PTR_WR:
                            r_next.ptr = lk.op_data;
                        OP_TBL_RD:
                        begin
                            r_next.rd_hi = r_reg.ptr[0];
                            r_next.st    = ST_RDWAIT;
                            if (lk.op_inc)
                                r_next.ptr = ptr_step(r_reg.ptr);
                        end
                        OP_HOLD_LD:
                        begin
                            // Short write into a holding register only.
                            r_next.hold[r_reg.ptr[HOLD_AW-1:0]] = lk.op_data[BYTE_W-1:0];
                            if (lk.op_inc)
                                r_next.ptr = ptr_step(r_reg.ptr);
                        end
                        OP_CTRL_WR:
                        begin
                            ctrl_wr_acc = 1'b1;
                            r_next.free = lk.op_data[CTRL_FREE];
                            r_next.write_enable_bit = lk.op_data[CTRL_WRITE_ENABLE_BIT];
                            // Launch only from an armed key sequence with write enable.
                            if (lk.op_data[CTRL_WR] && lk.op_data[CTRL_WRITE_ENABLE_BIT] &&
                                r_reg.key == KEY_ARMED)
                            begin
                                launch        = 1'b1;
                                r_next.wr     = 1'b1;
                                r_next.cnt    = '0;
                                r_next.idx    = '0;
                                r_next.idx_done = 1'b0;
                                if (lk.op_data[CTRL_FREE])
                                begin
                                    r_next.st   = ST_ERASE;
                                    r_next.base = {r_reg.ptr[ROW_LSB +: ROW_BITS],
                                                   ROW_WORD_W'(0)};
                                end
                                else
                                begin
                                    r_next.st   = ST_PROG;
                                    r_next.base = {r_reg.ptr[BLK_LSB +: WAW-BLK_WORD_W],
                                                   BLK_WORD_W'(0)};
                                end
                            end
                        end
                        OP_KEY_WR:
                        begin
                            if (lk.op_data[BYTE_W-1:0] == KEY_FIRST)
                                r_next.key = KEY_HALF;
                            else if (lk.op_data[BYTE_W-1:0] == KEY_SECOND &&
                                     r_reg.key == KEY_HALF)
                                r_next.key = KEY_ARMED;
                            else
                                r_next.key = KEY_NONE;
                        end
                        OP_CTRL_RD:
                        begin
                            r_next.rsp_valid = 1'b1;
                            r_next.rsp_data  = ctrl_byte(r_reg, abort_reg);
                        end
                        OP_LAT_RD:
                        begin
                            r_next.rsp_valid = 1'b1;
                            r_next.rsp_data  = r_reg.latch;
                        end
                        OP_KEY_RD:
                        begin
                            r_next.rsp_valid = 1'b1;
                            r_next.rsp_data  = '0;
                        end
                    endcase
                end
            end
            ST_RDWAIT:
            begin
                // One byte of the fetched word goes to the latch and back to the core.
                r_next.latch     = byte_of(mem_q, r_reg.rd_hi);
                r_next.rsp_valid = 1'b1;
                r_next.rsp_data  = byte_of(mem_q, r_reg.rd_hi);
                r_next.st        = ST_IDLE;
            end
            ST_ERASE, ST_PROG:
            begin
                // The array is rewritten one word per cycle inside the timed window.
                if (!r_reg.idx_done)
                begin
                    mem_we = 1'b1;
                    if (r_reg.st == ST_ERASE)
                        mem_wd = {ERASED_BYTE, ERASED_BYTE};
                    r_next.idx = r_reg.idx + 1'b1;
                    if (r_reg.idx == ((r_reg.st == ST_ERASE) ? ERASE_LAST : PROG_LAST))
                        r_next.idx_done = 1'b1;
                end
                r_next.cnt = r_reg.cnt + 1'b1;
                if (r_reg.cnt == CNT_LAST)
                begin
                    done      = 1'b1;
                    r_next.wr = 1'b0;
                    if (r_reg.st == ST_ERASE)
                        r_next.free = 1'b0;
                    // Holding registers are deliberately left as they are.
                    r_next.st = ST_IDLE;
                end
            end
        endcase
    end

    // Controller state register.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            r_reg <= '0;
        else if (ce)
            r_reg <= r_next;
    end

    // Abort flag survives rst_b so a reset mid-cycle stays visible; of the two resets only power-on (por_b) clears it.
    always_ff @(posedge mclk or negedge por_b)
    begin
        if (!por_b)
            abort_reg <= 1'b0;
        else if (ce)
        begin
            if (launch)
                abort_reg <= 1'b1;
            else if (done)
                abort_reg <= 1'b0;
            else if (ctrl_wr_acc)
                abort_reg <= lk.op_data[CTRL_ABORT];
        end
    end

    // Flash array: one write port for the sequencer, one registered read port.
    always_ff @(posedge mclk)
    begin
        if (ce)
        begin
            if (mem_we)
                mem[mem_wa] <= mem_wd;
            mem_q <= mem[r_reg.ptr[WAW:1]];
        end
    end
endmodule // fspc_device

// ---- rtl/fspc_core_end.sv ----
// Processor core end: turns register-port orders into link operations and keeps responses.
`timescale 1ns/1ns
module fspc_core_end
    import fspc_pkg::*;
(
    // Clock, reset and clock enable.
    input  wire logic          mclk,
    input  wire logic          rst_b,
    input  wire logic          ce,
    // Software register port.
    input  wire logic [3:0]    reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [31:0]   reg_rdata,
    // Link to the flash controller.
    fspc_link_if.core          lk
);
    import fspc_pkg::*;

    typedef struct packed {
        logic [PTR_W-1:0]   data;
        fspc_op_type        op;
        logic               inc;
        logic               pend;
        logic [BYTE_W-1:0]  rsp;
        logic               rsp_new;
        logic [31:0]        rdata;
    } fspc_core_type;

    fspc_core_type  r_reg;
    fspc_core_type  r_next;
    logic           issue;

    // An order goes out once the device stops stalling.
    assign issue       = r_reg.pend && !lk.stall && ce;
    assign lk.op_valid = issue;
    assign lk.op_code  = r_reg.op;
    assign lk.op_inc   = r_reg.inc;
    assign lk.op_data  = r_reg.data;
    assign reg_rdata   = r_reg.rdata;

    // Register decode, order queue of one and response capture.
    always_comb
    begin
        r_next = r_reg;
        if (issue)
            r_next.pend = 1'b0;
        if (reg_wr && reg_addr == REG_DATA)
            r_next.data = reg_wdata[PTR_W-1:0];
        // Orders are sent in the order software writes them, keys included.
        if (reg_wr && reg_addr == REG_CMD && !r_reg.pend)
        begin
            r_next.op   = fspc_op_type'(reg_wdata[2:0]);
            r_next.inc  = reg_wdata[CMD_INC];
            r_next.pend = 1'b1;
        end
        r_next.rdata = '0;
        if (reg_rd)
        begin
            unique case (reg_addr)
                REG_DATA: r_next.rdata = 32'(r_reg.data);
                REG_STAT:
                begin
                    r_next.rdata[STAT_BUSY] = r_reg.pend || lk.stall;
                    r_next.rdata[STAT_NEW]  = r_reg.rsp_new;
                end
                REG_RSP:
                begin
                    r_next.rdata   = 32'(r_reg.rsp);
                    r_next.rsp_new = 1'b0;
                end
                default: r_next.rdata = '0;
            endcase
        end
        // A response arriving with the clearing read still marks new data.
        if (lk.rsp_valid)
        begin
            r_next.rsp     = lk.rsp_data;
            r_next.rsp_new = 1'b1;
        end
    end

    // Core-end state register.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            r_reg <= '0;
        else if (ce)
            r_reg <= r_next;
    end
endmodule // fspc_core_end

// ---- testbench/fspc_link_properties.sv ----
// Concurrent checks on the link between the core end and the flash controller.
`timescale 1ns/1ns
module fspc_link_checker
    import fspc_pkg::*;
#(
    parameter int LONG_CYC = 600
)(
    // Clock and reset.
    input wire logic                 mclk,
    input wire logic                 rst_b,
    // Link signals.
    input wire logic                           op_valid,
    input wire fspc_pkg::fspc_op_type          op_code,
    input wire logic                           op_inc,
    input wire logic [fspc_pkg::PTR_W-1:0]     op_data,
    input wire logic                           stall,
    input wire logic                           rsp_valid,
    input wire logic [fspc_pkg::BYTE_W-1:0]    rsp_data
);
    import fspc_pkg::*;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    logic       taken;
    logic       launch_ok;
    logic [1:0] key_reg;
    int         run_reg;

    // An operation is taken whenever it is offered while the device is not stalling.
    assign taken = op_valid && !stall;
    assign launch_ok = taken && op_code == OP_CTRL_WR && op_data[CTRL_WR] && op_data[CTRL_WRITE_ENABLE_BIT]
                       && key_reg == 2'h2;

    // Tracks the unlock keys; any other taken operation disarms.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            key_reg <= 2'h0;
        else if (taken)
            key_reg <= (op_code == OP_KEY_WR && op_data[7:0] == KEY_FIRST) ? 2'h1 :
                       (op_code == OP_KEY_WR && op_data[7:0] == KEY_SECOND && key_reg == 2'h1)
                       ? 2'h2 : 2'h0;
    end

    // Counts the length of the current stall run.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            run_reg <= 0;
        else
            run_reg <= stall ? run_reg + 1 : 0;
    end

    property p_tbl_read;
        taken && op_code == OP_TBL_RD |=> stall ##1 (!stall && rsp_valid);
    endproperty
    a_tbl_read: assert property (p_tbl_read) else $error("table read timing wrong");

    property p_short_read;
        taken && op_code inside {OP_CTRL_RD, OP_LAT_RD} |=> rsp_valid && !stall;
    endproperty
    a_short_read: assert property (p_short_read) else $error("short read not answered");

    property p_key_zero;
        taken && op_code == OP_KEY_RD |=> rsp_valid && rsp_data == 8'h00;
    endproperty
    a_key_zero: assert property (p_key_zero) else $error("key read not zero");

    property p_hold_short;
        taken && op_code == OP_HOLD_LD |=> !stall && !rsp_valid;
    endproperty
    a_hold_short: assert property (p_hold_short) else $error("holding load stalled");

    property p_launch;
        launch_ok |=> stall [*8];
    endproperty
    a_launch: assert property (p_launch) else $error("keyed launch did not stall");

    property p_bad_launch;
        taken && op_code == OP_CTRL_WR && op_data[CTRL_WR] && !launch_ok |=> !stall;
    endproperty
    a_bad_launch: assert property (p_bad_launch) else $error("unkeyed launch ran");

    property p_long_len;
        $fell(stall) |-> run_reg == 1 || run_reg == LONG_CYC;
    endproperty
    a_long_len: assert property (p_long_len) else $error("stall run length wrong");

    property p_stall_quiet;
        stall |-> !rsp_valid && run_reg <= LONG_CYC;
    endproperty
    a_stall_quiet: assert property (p_stall_quiet) else $error("answer during stall");

    // Main scenarios reached.
    c_read: cover property (taken && op_code == OP_TBL_RD);
    c_launch: cover property (launch_ok);
    c_long_end: cover property ($fell(stall) && run_reg == LONG_CYC);
endmodule // fspc_link_checker

// ---- testbench/tb.sv ----
// Self-checking bench joining the core end and the flash controller across the link.
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
    $display("mismatch at %0t got %h expected %h", $time, (a), (b)); end end
module tb;
    import fspc_pkg::*;
    localparam int LONG = 600;
    typedef struct {fspc_op_type code; logic [7:0] data; logic [7:0] exp;} fspc_tb_row_type;

    logic        mclk;
    logic        rst_b;
    logic        por_b;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [7:0]  b;
    logic [31:0] w;
    int          err_total;
    int          n_compared;
    int          run;
    int          last_run;
    fspc_tb_row_type rows [15] = '{
        '{OP_CTRL_RD, 8'h00, 8'h00}, '{OP_KEY_RD, 8'h00, 8'h00}, '{OP_KEY_WR, 8'h55, 8'h00},
        '{OP_KEY_RD, 8'h00, 8'h00}, '{OP_CTRL_WR, 8'h06, 8'h00}, '{OP_CTRL_RD, 8'h00, 8'h04},
        '{OP_KEY_WR, 8'haa, 8'h00}, '{OP_KEY_WR, 8'h55, 8'h00}, '{OP_CTRL_WR, 8'h06, 8'h00},
        '{OP_CTRL_RD, 8'h00, 8'h04}, '{OP_KEY_WR, 8'h55, 8'h00}, '{OP_KEY_WR, 8'haa, 8'h00},
        '{OP_CTRL_WR, 8'h0a, 8'h00}, '{OP_CTRL_RD, 8'h00, 8'h08}, '{OP_CTRL_WR, 8'h00, 8'h00}};

    fspc_link_if lk_if ();
    fspc_device #(.ROW_BITS(1), .LONG_CYC(LONG)) u_fspc_device (
        .mclk(mclk), .rst_b(rst_b), .por_b(por_b), .ce(1'b1), .lk(lk_if.dev));
    fspc_core_end u_fspc_core_end (
        .mclk(mclk), .rst_b(rst_b), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lk(lk_if.core));
    fspc_link_checker #(.LONG_CYC(LONG)) u_chk (
        .mclk(mclk), .rst_b(rst_b), .op_valid(lk_if.op_valid), .op_code(lk_if.op_code),
        .op_inc(lk_if.op_inc), .op_data(lk_if.op_data), .stall(lk_if.stall),
        .rsp_valid(lk_if.rsp_valid), .rsp_data(lk_if.rsp_data));

    // Free-running 250 MHz clock.
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Measures each stall run so that long operations can be timed.
    always @(posedge mclk)
    begin
        if (lk_if.stall === 1'b1)
            run++;
        else
        begin
            if (run > 0)
                last_run = run;
            run = 0;
        end
    end

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One-cycle register write.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // One-cycle register read; data is taken in the following cycle.
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Issues one link operation and waits until the core end is no longer busy.
    task automatic op(input fspc_op_type c, input logic i, input logic [21:0] d);
        logic [31:0] s;
        int          k;
        wr(REG_DATA, {10'h000, d});
        wr(REG_CMD, {28'h0, i, c});
        k = 0;
        do
        begin
            rd(REG_STAT, s);
            k++;
        end
        while (s[STAT_BUSY] !== 1'b0 && k < 1000);
        if (k >= 1000)
            err_total++;
    endtask

    // Issues an operation that answers and fetches the answered byte.
    task automatic get(input fspc_op_type c, input logic i, input logic [21:0] d,
                       output logic [7:0] v);
        logic [31:0] r;
        op(c, i, d);
        rd(REG_RSP, r);
        v = r[7:0];
    endtask

    // Writes both unlock keys in order.
    task automatic keys();
        op(OP_KEY_WR, 1'b0, 22'h55);
        op(OP_KEY_WR, 1'b0, 22'haa);
    endtask

    // Cuts a hang short.
    initial
    begin
        repeat (50000) @(posedge mclk);
        err_total++;
        end_sim();
    end

    // Main sequence.
    initial
    begin
        rst_b = 1'b0;
        por_b = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        err_total = 0;
        n_compared = 0;
        run = 0;
        last_run = 0;
        repeat (12) @(posedge mclk);
        `CHK({lk_if.stall, lk_if.rsp_valid, reg_rdata}, 34'h0)
        rst_b <= 1'b1;
        por_b <= 1'b1;
        foreach (rows[n])
        begin
            get(rows[n].code, 1'b0, {14'h0, rows[n].data}, b);
            if (rows[n].code inside {OP_CTRL_RD, OP_KEY_RD})
                `CHK(b, rows[n].exp)
        end
        $display("test table done");
        op(OP_PTR_WR, 1'b0, 22'h0005a5);
        // The pointer order word reads back from the data register.
        rd(REG_DATA, w);
        `CHK(w, 32'h000005a5)
        op(OP_CTRL_WR, 1'b0, 22'h14);
        keys();
        op(OP_CTRL_WR, 1'b0, 22'h16);
        `CHK(last_run, LONG)
        get(OP_CTRL_RD, 1'b0, 22'h0, b);
        `CHK(b, 8'h04)
        get(OP_PTR_WR, 1'b0, 22'h0007ff, b);
        get(OP_TBL_RD, 1'b0, 22'h0, b);
        `CHK(b, ERASED_BYTE)
        $display("test erase done");
        op(OP_PTR_WR, 1'b0, 22'h000400);
        for (int i = 0; i < 64; i++)
            op(OP_HOLD_LD, 1'b1, {14'h0, 8'(i * 3 + 1)});
        op(OP_PTR_WR, 1'b0, 22'h000400);
        keys();
        op(OP_CTRL_WR, 1'b0, 22'h06);
        `CHK(last_run, LONG)
        op(OP_PTR_WR, 1'b0, 22'h000400);
        for (int i = 0; i < 65; i++)
        begin
            get(OP_TBL_RD, 1'b1, 22'h0, b);
            `CHK(b, (i < 64) ? 8'(i * 3 + 1) : ERASED_BYTE)
        end
        get(OP_LAT_RD, 1'b0, 22'h0, b);
        `CHK(b, ERASED_BYTE)
        $display("test program done");
        op(OP_PTR_WR, 1'b0, 22'h000440);
        keys();
        op(OP_CTRL_WR, 1'b0, 22'h06);
        op(OP_PTR_WR, 1'b0, 22'h000441);
        get(OP_TBL_RD, 1'b0, 22'h0, b);
        `CHK(b, 8'h04)
        // An unread answer shows as new data while the link is idle.
        op(OP_KEY_RD, 1'b0, 22'h0);
        rd(REG_STAT, w);
        `CHK(w, 32'h00000002)
        $display("test holding kept done");
        keys();
        wr(REG_DATA, 32'h06);
        wr(REG_CMD, {29'h0, OP_CTRL_WR});
        repeat (50) @(posedge mclk);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        get(OP_CTRL_RD, 1'b0, 22'h0, b);
        `CHK(b, 8'h08)
        $display("test reset in long cycle done");
        end_sim();
    end
endmodule // tb
